// file: src/utb_bridge.sv
/*
 utb_bridge: serial command receiver, two-wire bus primitive engine,
 spare pin access and reply transmitter.
 Assumes pull-ups on both bus lines and sampled pins from outside the
 clock domain; reply bytes pass through a two-entry buffer.
*/
`timescale 1ns/1ns
`default_nettype none
module utb_bridge
  import utb_pkg::*;
#(
  parameter int unsigned SPARE_PINS = 16,
  parameter int unsigned QTR_COUNT  = QTR_CYC
) (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  host_dtr,
  input  wire logic                  serial_pin_one,
  output logic                       serial_pin_two,
  input  wire logic                  twowire_line_a_i,
  output logic                       twowire_line_a_o,
  output logic                       twowire_line_a_oe_n,
  input  wire logic                  twowire_line_b_i,
  output logic                       twowire_line_b_o,
  output logic                       twowire_line_b_oe_n,
  input  wire logic [SPARE_PINS-1:0] spare_pin_i,
  output logic      [SPARE_PINS-1:0] spare_pin_o
);
  // bit 0 is the first synchroniser stage, read only by bit 1
  logic [1:0]            rx_sy_q, dtr_sy_q, sda_sy_q, scl_sy_q;
  logic [SPARE_PINS-1:0] spare_sy1_q, spare_sy2_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_sy_q     <= 2'h3;
      dtr_sy_q    <= 2'h3;
      sda_sy_q    <= 2'h3;
      scl_sy_q    <= 2'h3;
      spare_sy1_q <= '0;
      spare_sy2_q <= '0;
    end else begin
      rx_sy_q     <= {rx_sy_q[0], serial_pin_one};
      dtr_sy_q    <= {dtr_sy_q[0], host_dtr};
      sda_sy_q    <= {sda_sy_q[0], twowire_line_a_i};
      scl_sy_q    <= {scl_sy_q[0], twowire_line_b_i};
      spare_sy1_q <= spare_pin_i;
      spare_sy2_q <= spare_sy1_q;
    end
  end
  wire rx_in  = rx_sy_q[1];
  wire dtr_in = dtr_sy_q[1];
  wire sda_in = sda_sy_q[1];
  wire scl_in = scl_sy_q[1];
  wire master_clear_n = !(sys_rst || dtr_in);
  wire rst = !master_clear_n;

  // receiver: start bit checked at mid-bit, then 8 data, then stop
  logic       rx_busy_q, rx_vld_q;
  logic [8:0] rx_cnt_q;
  logic [3:0] rx_bit_q;
  logic [7:0] rx_sh_q, rx_byte_q;
  wire        rx_tick = rx_busy_q && (rx_cnt_q == '0);
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_busy_q <= 1'b0;
      rx_vld_q  <= 1'b0;
      rx_cnt_q  <= '0;
      rx_bit_q  <= '0;
      rx_sh_q   <= '0;
      rx_byte_q <= '0;
    end else begin
      rx_vld_q <= 1'b0;
      if (!rx_busy_q) begin
        rx_busy_q <= !rx_in;
        rx_cnt_q  <= 9'(HALF_CYC);
        rx_bit_q  <= '0;
      end else if (!rx_tick) begin
        rx_cnt_q <= rx_cnt_q - 1'b1;
      end else begin
        rx_cnt_q <= 9'(BAUD_CYC - 1);
        rx_bit_q <= rx_bit_q + 1'b1;
        if (rx_bit_q == '0 && rx_in) begin
          rx_busy_q <= 1'b0;
        end else if (rx_bit_q == 4'(FRAME_LAST)) begin
          rx_busy_q <= 1'b0;
          rx_vld_q  <= rx_in;
          rx_byte_q <= rx_sh_q;
        end else if (rx_bit_q != '0) begin
          rx_sh_q <= {rx_in, rx_sh_q[7:1]};
        end
      end
    end
  end

  // reply path: command engine -> buffer -> transmitter
  utb_strm_if #(.WIDTH(8)) rep_in ();
  utb_strm_if #(.WIDTH(8)) rep_out ();
  utb_fifo2 #(.WIDTH(8), .DEPTH(2)) u_rep_buf (
    .clk (clk),
    .rst (rst),
    .wr  (rep_in),
    .rd  (rep_out)
  );

  logic       tx_busy_q;
  logic [8:0] tx_cnt_q;
  logic [3:0] tx_bit_q;
  logic [9:0] tx_sh_q;
  assign rep_out.ready  = !tx_busy_q;
  assign serial_pin_two = tx_sh_q[0];
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_busy_q <= 1'b0;
      tx_cnt_q  <= '0;
      tx_bit_q  <= '0;
      tx_sh_q   <= '1;
    end else if (!tx_busy_q) begin
      if (rep_out.valid) begin
        tx_busy_q <= 1'b1;
        tx_sh_q   <= {1'b1, rep_out.data, 1'b0};
        tx_cnt_q  <= 9'(BAUD_CYC - 1);
        tx_bit_q  <= '0;
      end
    end else if (tx_cnt_q != '0) begin
      tx_cnt_q <= tx_cnt_q - 1'b1;
    end else begin
      tx_cnt_q  <= 9'(BAUD_CYC - 1);
      tx_bit_q  <= tx_bit_q + 1'b1;
      tx_sh_q   <= {1'b1, tx_sh_q[9:1]};
      tx_busy_q <= (tx_bit_q != 4'(FRAME_LAST));
    end
  end

  // command engine
  utb_state_type state_q;
  utb_opk_type   op_q;
  logic [7:0]    opc_q, opr_q, rep_q;
  logic [1:0]    ph_q;
  logic [3:0]    bit_q;
  logic [8:0]    txb_q, smp_q;
  logic          fail_q, sda_low_q, scl_low_q;
  logic [15:0]   q_cnt_q;
  logic [SPARE_PINS-1:0] spare_q;

  wire utb_opk_type kind = utb_kind(opc_q);
  wire [3:0] pin_idx  = opc_q[3:0];
  wire       pin_ok   = 32'(pin_idx) < SPARE_PINS;
  wire       pin_val  = spare_sy2_q[pin_idx];
  // pin replies are decoded while the operand is being taken; the pin index comes from the opcode
  wire       wr_arg   = (rx_byte_q[7:1] == '0);
  wire       in_exec  = (state_q == S_EXEC);
  wire       qtick    = in_exec && (q_cnt_q == '0);
  wire       is_bits  = op_q inside {OPK_WRITE, OPK_READ, OPK_TOGGLE};
  wire       ex_last  = qtick && ph_q == 2'h3
                        && (!is_bits || bit_q == 4'(TW_LAST));
  wire       bus_idle = sda_in && scl_in;
  // a stop only counts when both lines were seen to rise
  wire       stop_bad = (op_q == OPK_STOP) && !bus_idle;
  // a write must see its own bits and a low acknowledge
  wire       wr_bad   = (op_q == OPK_WRITE) && (smp_q != {opr_q, 1'b0});
  wire       tw_fail  = fail_q || wr_bad || stop_bad;
  wire [7:0] tw_rep   =
    tw_fail              ? REP_FAIL   :
    (op_q == OPK_START)  ? REP_START  :
    (op_q == OPK_WRITE)  ? REP_WRITE  :
    (op_q == OPK_READ)   ? smp_q[8:1] :
    (op_q == OPK_STOP)   ? REP_STOP   : REP_TOGGLE;
  wire [7:0] pin_rep  =
    (kind == OPK_PIN_RD && pin_ok) ? (pin_val ? REP_PIN_HI : REP_PIN_LO) :
    (kind == OPK_PIN_WR && pin_ok && wr_arg) ? REP_PIN_WR : REP_FAIL;
  wire [8:0] txb_init =
    (kind == OPK_WRITE) ? {rx_byte_q, 1'b1} :
    (kind == OPK_READ)  ? {8'hff, !rx_byte_q[ACK_POS]} : 9'h1ff;
  wire       opr_take = (state_q == S_OPR) && rx_vld_q;
  wire       tw_kind  = kind inside {OPK_START, OPK_WRITE, OPK_READ,
                                     OPK_STOP, OPK_TOGGLE};

  assign rep_in.valid = (state_q == S_PUSH) || (state_q == S_PUSH2);
  assign rep_in.data  = (state_q == S_PUSH2) ? REP_READ : rep_q;
  assign spare_pin_o  = spare_q;
  // lines are only ever pulled low or let go to the pull-ups
  assign twowire_line_a_o    = 1'b0;
  assign twowire_line_b_o    = 1'b0;
  assign twowire_line_a_oe_n = !sda_low_q;
  assign twowire_line_b_oe_n = !scl_low_q;

  // quarter-bit sequencer; each bit is four quarters long
  always_ff @(posedge clk) begin
    if (rst) begin
      ph_q      <= '0;
      bit_q     <= '0;
      txb_q     <= '1;
      smp_q     <= '0;
      fail_q    <= 1'b0;
      sda_low_q <= 1'b0;
      scl_low_q <= 1'b0;
    end else if (opr_take) begin
      ph_q   <= '0;
      bit_q  <= '0;
      txb_q  <= txb_init;
      fail_q <= 1'b0;
    end else if (qtick) begin
      ph_q <= ph_q + 1'b1;
      case (op_q)
        OPK_START: begin
          if (ph_q == 2'h0) sda_low_q <= 1'b0;
          if (ph_q == 2'h1) scl_low_q <= 1'b0;
          if (ph_q == 2'h2) begin
            sda_low_q <= 1'b1;
            fail_q    <= !bus_idle;
          end
          if (ph_q == 2'h3) scl_low_q <= 1'b1;
        end
        OPK_STOP: begin
          if (ph_q == 2'h0) begin
            scl_low_q <= 1'b1;
            sda_low_q <= 1'b1;
          end
          if (ph_q == 2'h1) scl_low_q <= 1'b0;
          if (ph_q == 2'h2) sda_low_q <= 1'b0;
        end
        OPK_WRITE, OPK_READ, OPK_TOGGLE: begin
          if (ph_q == 2'h0) begin
            scl_low_q <= 1'b1;
            sda_low_q <= !txb_q[8];
          end
          if (ph_q == 2'h1) scl_low_q <= 1'b0;
          if (ph_q == 2'h2) smp_q <= {smp_q[7:0], sda_in};
          if (ph_q == 2'h3) begin
            scl_low_q <= 1'b1;
            txb_q     <= {txb_q[7:0], 1'b1};
            bit_q     <= bit_q + 1'b1;
            if (bit_q == 4'(TW_LAST)) sda_low_q <= 1'b0;
          end
        end
        default: ph_q <= ph_q + 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !in_exec || q_cnt_q == '0) q_cnt_q <= 16'(QTR_COUNT - 1);
    else q_cnt_q <= q_cnt_q - 1'b1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= S_OPC;
      opc_q   <= '0;
      opr_q   <= '0;
      rep_q   <= '0;
      op_q    <= OPK_BAD;
      spare_q <= '0;
    end else begin
      case (state_q)
        S_OPC: if (rx_vld_q) begin
          opc_q   <= rx_byte_q;
          state_q <= S_OPR;
        end
        S_OPR: if (rx_vld_q) begin
          opr_q   <= rx_byte_q;
          op_q    <= kind;
          rep_q   <= pin_rep;
          state_q <= tw_kind ? S_EXEC : S_PUSH;
          if (kind == OPK_PIN_WR && pin_ok && wr_arg) begin
            spare_q[pin_idx] <= rx_byte_q[0];
          end
        end
        S_EXEC: if (ex_last) begin
          rep_q   <= tw_rep;
          state_q <= S_PUSH;
        end
        S_PUSH: if (rep_in.ready) begin
          state_q <= (op_q == OPK_READ && !tw_fail) ? S_PUSH2 : S_OPC;
        end
        S_PUSH2: if (rep_in.ready) state_q <= S_OPC;
        default: state_q <= S_OPC;
      endcase
    end
  end

  AST_SDA_OPEN_DRAIN: assert property (@(posedge clk)
    twowire_line_a_o == 1'b0)
    else $error("data line driven high");
  AST_SCL_OPEN_DRAIN: assert property (@(posedge clk)
    twowire_line_b_o == 1'b0)
    else $error("clock line driven high");
  AST_RESET_IDLE: assert property (@(posedge clk)
    rst |=> state_q == S_OPC && twowire_line_a_oe_n && twowire_line_b_oe_n)
    else $error("bridge not idle after reset");
  AST_FAIL_UNKNOWN: assert property (@(posedge clk) disable iff (rst)
    opr_take && kind == OPK_BAD |=> state_q == S_PUSH && rep_q == REP_FAIL)
    else $error("unknown opcode not refused");
  AST_OPC_WAITS: assert property (@(posedge clk) disable iff (rst)
    state_q == S_OPC |=> state_q == S_OPC || state_q == S_OPR)
    else $error("command ran on one byte");
  AST_REPLY_HOLDS: assert property (@(posedge clk) disable iff (rst)
    rep_in.valid && !rep_in.ready |=> rep_in.valid && $stable(rep_in.data))
    else $error("reply changed while stalled");
  AST_START_LOW: assert property (@(posedge clk) disable iff (rst)
    qtick && op_q == OPK_START && ph_q == 2'h3 |=> sda_low_q && scl_low_q)
    else $error("start left lines released");

  COV_TOGGLE: cover property (@(posedge clk) ex_last && op_q == OPK_TOGGLE);
  COV_READ2: cover property (@(posedge clk) state_q == S_PUSH2);
  COV_PIN_WR: cover property (@(posedge clk) opr_take && kind == OPK_PIN_WR);
endmodule : utb_bridge
`default_nettype wire

// file: src/utb_fifo2.sv
/*
 utb_fifo2: small buffer of DEPTH words (two by default) in the reply path.
 Assumes a synchronous active-high reset; DEPTH is a power of two.
*/
`timescale 1ns/1ns
`default_nettype none
module utb_fifo2 #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic   clk,
  input  wire logic   rst,
  utb_strm_if.snk     wr,
  utb_strm_if.src     rd
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wptr_q;
  logic [AW-1:0]    rptr_q;
  logic [AW:0]      cnt_q;
  wire              push = wr.valid && wr.ready;
  wire              pop  = rd.valid && rd.ready;

  assign wr.ready = (cnt_q < (AW+1)'(DEPTH));
  assign rd.valid = (cnt_q != '0);
  assign rd.data  = mem_q[rptr_q];

  always_ff @(posedge clk) begin
    if (push) mem_q[wptr_q] <= wr.data;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q  <= '0;
    end else begin
      if (push) wptr_q <= wptr_q + 1'b1;
      if (pop) rptr_q <= rptr_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  AST_FIFO_FULL_STALL: assert property (@(posedge clk) disable iff (rst)
    cnt_q == (AW+1)'(DEPTH) |-> !wr.ready)
    else $error("buffer accepts while full");
endmodule : utb_fifo2
`default_nettype wire

// file: src/utb_pkg.sv
/*
 utb_pkg: constants, opcodes, reply codes and state types of the serial to
 two-wire command bridge.
 Assumes a 25 MHz system clock; host framing is 8N1 at 57600 baud.
*/
// Contract
// - host serial link runs at 57600 baud
// - A0h makes start, replies B0 or FA
// - A1h writes operand byte, replies B1 or FA
// - A2h reads byte, ack per operand, data+B2
// - A3h makes stop, replies A3 or FA
// - A4h pulses clock nine times, replies A4
// - Eh? samples spare pin, replies 00/01/FA
// - Fh? drives spare pin from operand, replies F0; code replies FA unless operand is 00/01
// - low opcode nibble selects the spare pin
// - bus lines only pulled low or released
// - terminal-ready high holds bridge in reset
// - only generic primitives, no target knowledge
// - two bytes per command, run after second
// - unknown opcode replies FA
// - success only on expected bus acknowledge
package utb_pkg;
  localparam int unsigned SYS_CLK_HZ = 25_000_000;
  localparam int unsigned BAUD_RATE  = 57_600;
  localparam int unsigned BAUD_CYC   = SYS_CLK_HZ / BAUD_RATE;
  localparam int unsigned HALF_CYC   = BAUD_CYC / 2;
  localparam int unsigned QTR_NS     = 2500;
  localparam int unsigned QTR_CYC    =
    (QTR_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned FRAME_LAST = 9;
  localparam int unsigned TW_LAST    = 8;
  localparam int unsigned ACK_POS    = 0;

  localparam logic [7:0] OPC_START  = 8'ha0;
  localparam logic [7:0] OPC_WRITE  = 8'ha1;
  localparam logic [7:0] OPC_READ   = 8'ha2;
  localparam logic [7:0] OPC_STOP   = 8'ha3;
  localparam logic [7:0] OPC_TOGGLE = 8'ha4;
  localparam logic [3:0] OPC_PIN_RD = 4'he;
  localparam logic [3:0] OPC_PIN_WR = 4'hf;

  localparam logic [7:0] REP_START  = 8'hb0;
  localparam logic [7:0] REP_WRITE  = 8'hb1;
  localparam logic [7:0] REP_READ   = 8'hb2;
  localparam logic [7:0] REP_STOP   = 8'ha3;
  localparam logic [7:0] REP_TOGGLE = 8'ha4;
  localparam logic [7:0] REP_PIN_LO = 8'h00;
  localparam logic [7:0] REP_PIN_HI = 8'h01;
  localparam logic [7:0] REP_PIN_WR = 8'hf0;
  localparam logic [7:0] REP_FAIL   = 8'hfa;

  typedef enum logic [2:0] {
    OPK_START  = 3'h0,
    OPK_WRITE  = 3'h1,
    OPK_READ   = 3'h2,
    OPK_STOP   = 3'h3,
    OPK_TOGGLE = 3'h4,
    OPK_PIN_RD = 3'h5,
    OPK_PIN_WR = 3'h6,
    OPK_BAD    = 3'h7
  } utb_opk_type;

  typedef enum logic [4:0] {
    S_OPC   = 5'h01,
    S_OPR   = 5'h02,
    S_EXEC  = 5'h04,
    S_PUSH  = 5'h08,
    S_PUSH2 = 5'h10
  } utb_state_type;

  function automatic utb_opk_type utb_kind(input logic [7:0] opc);
    utb_opk_type k;
    k = OPK_BAD;
    if (opc == OPC_START) k = OPK_START;
    else if (opc == OPC_WRITE) k = OPK_WRITE;
    else if (opc == OPC_READ) k = OPK_READ;
    else if (opc == OPC_STOP) k = OPK_STOP;
    else if (opc == OPC_TOGGLE) k = OPK_TOGGLE;
    else if (opc[7:4] == OPC_PIN_RD) k = OPK_PIN_RD;
    else if (opc[7:4] == OPC_PIN_WR) k = OPK_PIN_WR;
    return k;
  endfunction : utb_kind
endpackage : utb_pkg

// file: src/utb_strm_if.sv
/*
 utb_strm_if: valid/ready byte stream between bridge modules.
 Assumes both ends share one clock; a word moves when valid and ready.
*/
`timescale 1ns/1ns
`default_nettype none
interface utb_strm_if #(parameter int unsigned WIDTH = 8);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : utb_strm_if
`default_nettype wire

// file: tb/tb_uart_to_twowire_command_bridge.sv
/*
 tb_uart_to_twowire_command_bridge: runs every command through the host.
 Assumes no target on the bus, so pull-ups alone set the idle level.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_uart_to_twowire_command_bridge;
  import utb_pkg::*;
  localparam int unsigned PINS = 16;
  localparam int          WAIT = 30 * BAUD_CYC;
  logic            clk, sys_rst, host_dtr, rx_w, tx_w;
  logic            a_i, a_o, a_oe_n, b_i, b_o, b_oe_n;
  logic [PINS-1:0] spare_i, spare_o;
  logic [7:0]      b;
  logic            ok, v;
  logic [3:0]      p;
  int              fails, check_count, falls, seed;

  assign a_i = (a_oe_n === 1'b0) ? a_o : 1'b1;
  assign b_i = (b_oe_n === 1'b0) ? b_o : 1'b1;

  utb_bridge #(.SPARE_PINS(PINS), .QTR_COUNT(4)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .host_dtr(host_dtr),
    .serial_pin_one(rx_w), .serial_pin_two(tx_w),
    .twowire_line_a_i(a_i), .twowire_line_a_o(a_o),
    .twowire_line_a_oe_n(a_oe_n), .twowire_line_b_i(b_i),
    .twowire_line_b_o(b_o), .twowire_line_b_oe_n(b_oe_n),
    .spare_pin_i(spare_i), .spare_pin_o(spare_o)
  );
  utb_host_model host_u (.clk(clk), .tx_line(rx_w), .rx_line(tx_w));

  initial clk = 1'b0;
  always #20 clk = ~clk;
  // data stays released during the toggle, so the sum counts clock pulses
  always @(negedge a_i or negedge b_i) falls++;

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp,
                            input string msg);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s %h not %h", $time, msg, got, exp);
    end
  endtask : check_byte

  task automatic check_bit(input logic got, input logic exp,
                           input string msg);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s %b not %b", $time, msg, got, exp);
    end
  endtask : check_bit

  function automatic logic [7:0] exp_pin(input logic lvl);
    return lvl ? REP_PIN_HI : REP_PIN_LO;
  endfunction : exp_pin

  function automatic logic [7:0] idle_byte();
    return 8'hff;
  endfunction : idle_byte

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up

  task automatic do_cmd(input logic [7:0] opc, input logic [7:0] opr,
                        input logic [7:0] exp0);
    host_u.send_byte(opc);
    // the reply may start during the operand's stop bit, so listen at once
    fork
      host_u.send_byte(opr);
      host_u.recv_byte(WAIT, b, ok);
    join
    check_bit(ok, 1'b1, "reply framing");
    check_byte(b, exp0, "reply");
  endtask : do_cmd

  always @(posedge clk) begin
    if (!sys_rst && a_oe_n === 1'b0) check_bit(a_o, 1'b0, "line a");
    if (!sys_rst && b_oe_n === 1'b0) check_bit(b_o, 1'b0, "line b");
  end

  initial begin
    repeat (110000) @(posedge clk);
    fails++;
    $display("wrong value at %0t: run hung", $time);
    wrap_up();
  end

  initial begin
    seed = 32'hbc17;
    sys_rst = 1'b1;
    host_dtr = 1'b0;
    spare_i = '0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    do_cmd(OPC_START, 8'h00, REP_START);
    do_cmd(OPC_WRITE, 8'h40, REP_FAIL);
    falls = 0;
    do_cmd(OPC_TOGGLE, 8'h00, REP_TOGGLE);
    check_byte(falls[7:0], 8'h09, "clock pulses");
    do_cmd(OPC_READ, 8'h00, idle_byte());
    host_u.recv_byte(WAIT, b, ok);
    check_byte(b, REP_READ, "read status");
    do_cmd(OPC_STOP, 8'h00, REP_STOP);
    p = 4'($random(seed));
    v = 1'($random(seed));
    do_cmd({OPC_PIN_WR, p}, {7'h00, v}, REP_PIN_WR);
    check_bit(spare_o[p], v, "pin drive");
    @(posedge clk);
    spare_i <= PINS'($random(seed));
    p = 4'($random(seed));
    @(posedge clk);
    do_cmd({OPC_PIN_RD, p}, 8'h00, exp_pin(spare_i[p]));
    // a byte sent in reset must not pair with the next one
    @(posedge clk);
    host_dtr <= 1'b1;
    host_u.send_byte(OPC_STOP);
    @(posedge clk);
    host_dtr <= 1'b0;
    repeat (8) @(posedge clk);
    fork
      begin
        host_u.send_byte(8'ha5);
        host_u.send_byte(8'h00);
      end
      begin
        host_u.recv_byte(10 * BAUD_CYC, b, ok);
        check_bit(ok, 1'b0, "reply after one byte");
        host_u.recv_byte(WAIT, b, ok);
      end
    join
    check_byte(b, REP_FAIL, "unknown opcode");
    wrap_up();
  end
endmodule : tb_uart_to_twowire_command_bridge
`default_nettype wire

// file: tb/utb_host_model.sv
/*
 utb_host_model: host end of the serial link, sends and takes 8N1 bytes.
 Assumes the bridge clock; the host line idles high between characters.
*/
`timescale 1ns/1ns
`default_nettype none
module utb_host_model
  import utb_pkg::*;
(
  input  wire logic clk,
  output logic      tx_line,
  input  wire logic rx_line
);
  initial tx_line = 1'b1;

  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      tx_line <= fr[i];
      repeat (BAUD_CYC - 1) @(posedge clk);
    end
  endtask : send_byte

  // sampling mid-bit keeps a clock or two of skew harmless
  task automatic recv_byte(input int limit, output logic [7:0] b,
                           output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    b = 8'h00;
    while (rx_line !== 1'b0 && n < limit) begin
      @(posedge clk);
      n++;
    end
    if (rx_line === 1'b0) begin
      repeat (HALF_CYC) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BAUD_CYC) @(posedge clk);
        b[i] = rx_line;
      end
      repeat (BAUD_CYC) @(posedge clk);
      ok = (rx_line === 1'b1);
    end
  endtask : recv_byte
endmodule : utb_host_model
`default_nettype wire
